// ### shared/hbsr_pkg.sv
`default_nettype none
package hbsr_pkg;
	// Serial frame layout: bit 0 travels first, the address byte is the low half
	localparam int FRAME_BITS = 16;
	localparam int ADDR_BITS = 8;
	localparam int OP_BIT = 7;
	localparam int FLAG_BIT = 1;
	localparam int ONE_BIT = 0;
	localparam int SEL_HI = 6;
	localparam int SEL_LO = 2;

	// Register select patterns, A6 down to A2
	localparam logic [4:0] SEL_EN_LO = 5'h00;
	localparam logic [4:0] SEL_EN_HI = 5'h10;
	localparam logic [4:0] SEL_ROUTE_LO = 5'h18;
	localparam logic [4:0] SEL_ROUTE_HI = 5'h04;
	localparam logic [4:0] SEL_RATE = 5'h0c;
	localparam logic [4:0] SEL_DUTY1 = 5'h1c;
	localparam logic [4:0] SEL_DUTY2 = 5'h02;
	localparam logic [4:0] SEL_DUTY3 = 5'h12;
	localparam logic [4:0] SEL_IDENT = 5'h19;
	localparam logic [4:0] SEL_OVP_FAST = 5'h03;
	localparam logic [4:0] SEL_RSVD_A = 5'h13;
	localparam logic [4:0] SEL_OL_DT_SR = 5'h07;
	localparam logic [4:0] SEL_RSVD_B = 5'h17;
	localparam logic [4:0] SEL_GLOBAL = 5'h06;
	localparam logic [4:0] SEL_OC_LO = 5'h16;
	localparam logic [4:0] SEL_OC_HI = 5'h0e;
	localparam logic [4:0] SEL_OL_LO = 5'h01;
	localparam logic [4:0] SEL_OL_HI = 5'h11;

	// Storage slots of the control and status banks
	localparam int CTL_COUNT = 12;
	localparam int STA_COUNT = 5;
	localparam logic [3:0] CTL_NONE = 4'hf;
	localparam logic [2:0] STA_NONE = 3'h7;
	localparam logic [3:0] CI_EN_LO = 4'h0;
	localparam logic [3:0] CI_EN_HI = 4'h1;
	localparam logic [3:0] CI_ROUTE_LO = 4'h2;
	localparam logic [3:0] CI_ROUTE_HI = 4'h3;
	localparam logic [3:0] CI_RATE = 4'h4;
	localparam logic [3:0] CI_DUTY1 = 4'h5;
	localparam logic [3:0] CI_DUTY2 = 4'h6;
	localparam logic [3:0] CI_DUTY3 = 4'h7;
	localparam logic [3:0] CI_OVP_FAST = 4'h8;
	localparam logic [3:0] CI_RSVD_A = 4'h9;
	localparam logic [3:0] CI_OL_DT_SR = 4'ha;
	localparam logic [3:0] CI_RSVD_B = 4'hb;
	localparam logic [2:0] SI_GLOBAL = 3'h0;
	localparam logic [2:0] SI_OC_LO = 3'h1;
	localparam logic [2:0] SI_OC_HI = 3'h2;
	localparam logic [2:0] SI_OL_LO = 3'h3;
	localparam logic [2:0] SI_OL_HI = 3'h4;

	// Writable bits per control slot; reserved bits stay zero
	localparam logic [7:0] MASK_FULL = 8'hff;
	localparam logic [7:0] MASK_OVP_FAST = 8'hf0;
	localparam logic [7:0] MASK_OL_DT_SR = 8'h37;
	localparam logic [7:0] MASK_NONE = 8'h00;

	// Global status bit positions
	localparam int GS_FRAME_ERR = 7;
	localparam int GS_EVENT_LO = 1;

	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] GLOBAL_RESET = 8'h08;
	localparam logic [7:0] STA_RESET = 8'h00;

	// Host register map, APB byte addresses
	localparam logic [7:0] HOST_CMD = 8'h00;
	localparam logic [7:0] HOST_STAT = 8'h04;
	localparam logic [7:0] HOST_RESP = 8'h08;

	// Link timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int SCK_PERIOD_NS = 800;
	localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

	function automatic logic [3:0] hbsr_ctl_index(input logic [4:0] sel);
		unique case (sel)
			SEL_EN_LO: return CI_EN_LO;
			SEL_EN_HI: return CI_EN_HI;
			SEL_ROUTE_LO: return CI_ROUTE_LO;
			SEL_ROUTE_HI: return CI_ROUTE_HI;
			SEL_RATE: return CI_RATE;
			SEL_DUTY1: return CI_DUTY1;
			SEL_DUTY2: return CI_DUTY2;
			SEL_DUTY3: return CI_DUTY3;
			SEL_OVP_FAST: return CI_OVP_FAST;
			SEL_RSVD_A: return CI_RSVD_A;
			SEL_OL_DT_SR: return CI_OL_DT_SR;
			SEL_RSVD_B: return CI_RSVD_B;
			default: return CTL_NONE;
		endcase
	endfunction : hbsr_ctl_index

	function automatic logic [2:0] hbsr_sta_index(input logic [4:0] sel);
		unique case (sel)
			SEL_GLOBAL: return SI_GLOBAL;
			SEL_OC_LO: return SI_OC_LO;
			SEL_OC_HI: return SI_OC_HI;
			SEL_OL_LO: return SI_OL_LO;
			SEL_OL_HI: return SI_OL_HI;
			default: return STA_NONE;
		endcase
	endfunction : hbsr_sta_index

	function automatic logic [7:0] hbsr_ctl_mask(input logic [3:0] idx);
		unique case (idx)
			CI_OVP_FAST: return MASK_OVP_FAST;
			CI_OL_DT_SR: return MASK_OL_DT_SR;
			CI_RSVD_A, CI_RSVD_B, CTL_NONE: return MASK_NONE;
			default: return MASK_FULL;
		endcase
	endfunction : hbsr_ctl_mask
endpackage : hbsr_pkg
`default_nettype wire

// ### shared/hbsr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface hbsr_if;
	logic sck;
	logic csn;
	logic mosi;
	logic miso;
	modport dev (input sck, input csn, input mosi, output miso);
	modport host (output sck, output csn, output mosi, input miso);
endinterface : hbsr_if
`default_nettype wire

// ### hw/hbsr_device.sv
// How it works
// - Control access bit 0 reads, 1 writes.
// - Status access bit 1 clears, 0 reads.
// - Address byte: access, select, flag, one.
// - Data byte in frame bits 15..8.
// - Two switch-enable registers, pairs high first.
// - Two route registers, two bits per bridge.
// - Rate register: modulation plus three channels.
// - Three full-byte duty registers.
// - Read-only identification nibble, upper bits zero.
// - Overvoltage option and fast-rate selects.
// - Openload disable, deadtime and slew fields.
// - Two reserved slots still decoded.
// - Global status flags layout.
// - Overcurrent flags per switch.
// - Openload flags per switch.
// - Route code selects PWM source; the device only drives the route field out on bridge_route_field_out.
// - Both enables set turns bridge off.
// - Control registers reset to zero.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module hbsr_device #(
	// Arbitrary identification value
	parameter logic [3:0] PART_IDENT = 4'h5
) (
	input wire logic clk_in,
	input wire logic rst_in,
	hbsr_if.dev link,
	input wire logic [5:0] global_event_in,
	input wire logic [15:0] overcurrent_event_in,
	input wire logic [15:0] openload_event_in,
	output logic [7:0] high_side_on_out,
	output logic [7:0] low_side_on_out,
	output logic [15:0] bridge_route_field_out,
	output logic [7:0] channel_rate_register_out,
	output logic [7:0] duty_byte_one_out,
	output logic [7:0] duty_byte_two_out,
	output logic [7:0] duty_byte_three_out,
	output logic [7:0] overvoltage_fast_rate_out,
	output logic [7:0] openload_deadtime_slew_out,
	output logic [7:0] global_diagnosis_out
);
	typedef struct packed {
		logic [2:0] sck_p;
		logic [2:0] cs_p;
		logic [1:0] mo_p;
		logic [4:0] cnt;
		logic [15:0] rx;
		logic [7:0] tx;
		logic [hbsr_pkg::CTL_COUNT-1:0][7:0] ctl;
		logic [hbsr_pkg::STA_COUNT-1:0][7:0] sta;
	} hbsr_dev_state_t;

	hbsr_dev_state_t st_ff;
	hbsr_dev_state_t nxt_st;

	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;
	logic cs_active;
	logic [7:0] rd_byte;
	logic [hbsr_pkg::STA_COUNT-1:0][7:0] sta_set;
	logic [hbsr_pkg::STA_COUNT-1:0] sta_clr;
	logic frame_err;
	logic [15:0] enables;

	// Edges come from the second and third stages; the first stage is left alone
	assign sck_rise = st_ff.sck_p[1] & ~st_ff.sck_p[2];
	assign sck_fall = ~st_ff.sck_p[1] & st_ff.sck_p[2];
	assign cs_fall = ~st_ff.cs_p[1] & st_ff.cs_p[2];
	assign cs_rise = st_ff.cs_p[1] & ~st_ff.cs_p[2];
	assign cs_active = ~st_ff.cs_p[1];

	// Read mux on the address byte held after the eighth bit
	always_comb begin
		logic [3:0] ci;
		logic [2:0] si;
		logic [4:0] sel;
		// A6..A2 sit one byte up while only the address byte is in
		sel = st_ff.rx[hbsr_pkg::SEL_HI + hbsr_pkg::ADDR_BITS:
			hbsr_pkg::SEL_LO + hbsr_pkg::ADDR_BITS];
		ci = hbsr_pkg::hbsr_ctl_index(sel);
		si = hbsr_pkg::hbsr_sta_index(sel);
		rd_byte = 8'h00;
		if (st_ff.rx[8]) begin
			if (ci != hbsr_pkg::CTL_NONE) begin
				rd_byte = st_ff.ctl[ci] & hbsr_pkg::hbsr_ctl_mask(ci);
			end else if (sel == hbsr_pkg::SEL_IDENT) begin
				rd_byte = {4'h0, PART_IDENT};
			end else if (si != hbsr_pkg::STA_NONE) begin
				rd_byte = st_ff.sta[si];
			end
		end
	end

	always_comb begin
		logic [3:0] wci;
		logic [2:0] wsi;
		nxt_st = st_ff;
		sta_clr = '0;
		frame_err = 1'b0;
		wci = hbsr_pkg::hbsr_ctl_index(st_ff.rx[hbsr_pkg::SEL_HI:hbsr_pkg::SEL_LO]);
		wsi = hbsr_pkg::hbsr_sta_index(st_ff.rx[hbsr_pkg::SEL_HI:hbsr_pkg::SEL_LO]);
		nxt_st.sck_p = {st_ff.sck_p[1:0], link.sck};
		nxt_st.cs_p = {st_ff.cs_p[1:0], link.csn};
		nxt_st.mo_p = {st_ff.mo_p[0], link.mosi};
		if (cs_fall) begin
			nxt_st.cnt = 5'h00;
			// Global status answers during the address byte
			nxt_st.tx = st_ff.sta[hbsr_pkg::SI_GLOBAL];
		end else if (cs_active) begin
			if (sck_rise) begin
				// Bit 0 first, data lands high
				nxt_st.rx = {st_ff.mo_p[1], st_ff.rx[15:1]};
				if (st_ff.cnt != 5'h1f) begin
					nxt_st.cnt = st_ff.cnt + 5'h01;
				end
			end
			if (sck_fall) begin
				if (st_ff.cnt == 5'(hbsr_pkg::ADDR_BITS)) begin
					nxt_st.tx = rd_byte;
				end else begin
					nxt_st.tx = {1'b0, st_ff.tx[7:1]};
				end
			end
		end
		if (cs_rise) begin
			if (st_ff.cnt != 5'(hbsr_pkg::FRAME_BITS)) begin
				// Short or long frames change nothing and raise the frame error
				frame_err = 1'b1;
			end else if (st_ff.rx[hbsr_pkg::ONE_BIT] && st_ff.rx[hbsr_pkg::OP_BIT]) begin
				if (wci != hbsr_pkg::CTL_NONE) begin
					nxt_st.ctl[wci] = st_ff.rx[15:8] & hbsr_pkg::hbsr_ctl_mask(wci);
				end
				if (wsi != hbsr_pkg::STA_NONE) begin
					sta_clr[wsi] = 1'b1;
				end
			end
		end
		sta_set[hbsr_pkg::SI_GLOBAL] = {frame_err, global_event_in, 1'b0};
		sta_set[hbsr_pkg::SI_OC_LO] = overcurrent_event_in[7:0];
		sta_set[hbsr_pkg::SI_OC_HI] = overcurrent_event_in[15:8];
		sta_set[hbsr_pkg::SI_OL_LO] = openload_event_in[7:0];
		sta_set[hbsr_pkg::SI_OL_HI] = openload_event_in[15:8];
		for (int k = 0; k < hbsr_pkg::STA_COUNT; k++) begin
			nxt_st.sta[k] = (sta_clr[k] ? 8'h00 : st_ff.sta[k]) | sta_set[k];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_ff.sck_p <= 3'h0;
			st_ff.cs_p <= 3'h7;
			st_ff.mo_p <= 2'h0;
			st_ff.cnt <= 5'h00;
			st_ff.rx <= 16'h0000;
			st_ff.tx <= 8'h00;
			st_ff.ctl <= {hbsr_pkg::CTL_COUNT{hbsr_pkg::CTL_RESET}};
			st_ff.sta <= {{(hbsr_pkg::STA_COUNT-1){hbsr_pkg::STA_RESET}}, hbsr_pkg::GLOBAL_RESET};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign link.miso = st_ff.tx[0];

	assign enables = {st_ff.ctl[hbsr_pkg::CI_EN_HI], st_ff.ctl[hbsr_pkg::CI_EN_LO]};
	for (genvar b = 0; b < 8; b++) begin : g_bridge
		assign high_side_on_out[b] = enables[2*b+1] & ~enables[2*b];
		assign low_side_on_out[b] = enables[2*b] & ~enables[2*b+1];
	end

	assign bridge_route_field_out = {st_ff.ctl[hbsr_pkg::CI_ROUTE_HI], st_ff.ctl[hbsr_pkg::CI_ROUTE_LO]};
	assign channel_rate_register_out = st_ff.ctl[hbsr_pkg::CI_RATE];
	assign duty_byte_one_out = st_ff.ctl[hbsr_pkg::CI_DUTY1];
	assign duty_byte_two_out = st_ff.ctl[hbsr_pkg::CI_DUTY2];
	assign duty_byte_three_out = st_ff.ctl[hbsr_pkg::CI_DUTY3];
	assign overvoltage_fast_rate_out = st_ff.ctl[hbsr_pkg::CI_OVP_FAST];
	assign openload_deadtime_slew_out = st_ff.ctl[hbsr_pkg::CI_OL_DT_SR];
	assign global_diagnosis_out = st_ff.sta[hbsr_pkg::SI_GLOBAL];
endmodule : hbsr_device
`default_nettype wire

// ### hw/hbsr_host.sv
`timescale 1ns/10ps
`default_nettype none
module hbsr_host #(
	parameter int HALF_CYC = hbsr_pkg::SCK_HALF_CYC
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	hbsr_if.host link
);
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_SETUP = 2'b01,
		H_RUN = 2'b11,
		H_END = 2'b10
	} hbsr_hstate_t;

	typedef struct packed {
		hbsr_hstate_t st;
		logic [7:0] div;
		logic sck;
		logic csn;
		logic [4:0] bits;
		logic [15:0] tx;
		logic [15:0] rx;
		logic [15:0] resp;
		logic [1:0] mi_p;
		logic ack;
		logic [31:0] prdata;
	} hbsr_host_state_t;

	hbsr_host_state_t st_ff;
	hbsr_host_state_t nxt_st;
	logic access;
	logic tick;

	assign access = psel_in & penable_in;
	assign tick = st_ff.div == 8'(HALF_CYC - 1);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.mi_p = {st_ff.mi_p[0], link.miso};
		// One wait state: read data is registered before pready rises
		nxt_st.ack = access & ~st_ff.ack;
		if (access && !st_ff.ack) begin
			unique case (paddr_in)
				hbsr_pkg::HOST_STAT: nxt_st.prdata = {31'h0, st_ff.st != H_IDLE};
				hbsr_pkg::HOST_RESP: nxt_st.prdata = {16'h0000, st_ff.resp};
				default: nxt_st.prdata = 32'h0000_0000;
			endcase
		end
		if (st_ff.st != H_IDLE) begin
			nxt_st.div = tick ? 8'h00 : st_ff.div + 8'h01;
		end
		unique case (st_ff.st)
			H_IDLE: begin
				// Command written while busy is dropped
				if (access && st_ff.ack && pwrite_in && paddr_in == hbsr_pkg::HOST_CMD) begin
					nxt_st.tx = pwdata_in[15:0];
					nxt_st.csn = 1'b0;
					nxt_st.div = 8'h00;
					nxt_st.st = H_SETUP;
				end
			end
			H_SETUP: begin
				if (tick) begin
					nxt_st.sck = 1'b1;
					nxt_st.bits = 5'h00;
					nxt_st.st = H_RUN;
				end
			end
			H_RUN: begin
				if (tick) begin
					if (st_ff.sck) begin
						// Sample late in the high phase to absorb the far end's latency
						nxt_st.sck = 1'b0;
						nxt_st.rx = {st_ff.mi_p[1], st_ff.rx[15:1]};
						nxt_st.tx = {1'b0, st_ff.tx[15:1]};
						nxt_st.bits = st_ff.bits + 5'h01;
						if (st_ff.bits == 5'(hbsr_pkg::FRAME_BITS - 1)) begin
							nxt_st.st = H_END;
						end
					end else begin
						nxt_st.sck = 1'b1;
					end
				end
			end
			H_END: begin
				if (tick) begin
					if (!st_ff.csn) begin
						nxt_st.csn = 1'b1;
						nxt_st.resp = st_ff.rx;
					end else begin
						nxt_st.st = H_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_ff <= '0;
			st_ff.csn <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign link.sck = st_ff.sck;
	assign link.csn = st_ff.csn;
	assign link.mosi = st_ff.tx[0];
	assign prdata_out = st_ff.prdata;
	assign pready_out = access & st_ff.ack;
	assign pslverr_out = 1'b0;
endmodule : hbsr_host
`default_nettype wire

// ### verif/hbsr_properties.sv
`timescale 1ns/10ps
`default_nettype none
module hbsr_properties (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic sck_in,
	input wire logic csn_in,
	input wire logic mosi_in,
	input wire logic miso_in
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic [4:0] rise_ff;
	logic [4:0] nxt_rise;
	logic sck_d_ff;
	// Rises are counted per frame so a short or long frame shows at csn release
	always_comb begin
		nxt_rise = rise_ff;
		if (csn_in)
			nxt_rise = 5'h00;
		else if (sck_in && !sck_d_ff)
			nxt_rise = rise_ff + 5'h01;
	end
	always_ff @(posedge clk_in) begin
		sck_d_ff <= rst_in ? 1'b0 : sck_in;
		rise_ff <= rst_in ? 5'h00 : nxt_rise;
	end
	idle_clock_a: assert property (csn_in |-> !sck_in)
		else $error("serial clock moved while deselected");
	sck_select_a: assert property ($rose(sck_in) |-> !csn_in)
		else $error("serial clock rose outside a frame");
	lead_time_a: assert property ($fell(csn_in) |-> !sck_in [*4] ##1 sck_in)
		else $error("first clock rise not four cycles after select");
	high_phase_a: assert property ($rose(sck_in) |-> sck_in [*4] ##1 !sck_in)
		else $error("clock high phase not four cycles");
	mosi_hold_a: assert property (sck_in && $past(sck_in) |-> $stable(mosi_in))
		else $error("host data changed while clock high");
	miso_hold_a: assert property (sck_in && $past(sck_in) |-> $stable(miso_in))
		else $error("device data changed while clock high");
	frame_len_a: assert property ($fell(csn_in) |-> ##[128:136] $rose(csn_in))
		else $error("frame length out of range");
	bit_count_a: assert property ($rose(csn_in) |-> rise_ff == 5'h10)
		else $error("frame did not carry sixteen bits");
	csn_gap_a: assert property ($rose(csn_in) |-> csn_in [*3])
		else $error("select gap too short");
	cover property ($rose(csn_in));
	cover property ($fell(csn_in) ##[1:8] $rose(sck_in));
	cover property (!csn_in && miso_in);
endmodule : hbsr_properties
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	// Arbitrary identification value
	localparam logic [3:0] IDENT = 4'h5;
	logic clk_in, rst_in, psel, penable, pwrite, pready;
	logic [7:0] paddr, gd, hs, ls, rate, d1, d2, d3, ovp, olds, ehs, els;
	logic [31:0] pwdata, prdata;
	logic [5:0] gev;
	logic [15:0] oc, ol, route, rsp;
	int errors = 0;
	int check_count = 0;
	logic [4:0] sels [13] = '{hbsr_pkg::SEL_EN_LO, hbsr_pkg::SEL_EN_HI, hbsr_pkg::SEL_ROUTE_LO,
		hbsr_pkg::SEL_ROUTE_HI, hbsr_pkg::SEL_RATE, hbsr_pkg::SEL_DUTY1, hbsr_pkg::SEL_DUTY2,
		hbsr_pkg::SEL_DUTY3, hbsr_pkg::SEL_OVP_FAST, hbsr_pkg::SEL_RSVD_A,
		hbsr_pkg::SEL_OL_DT_SR, hbsr_pkg::SEL_RSVD_B, hbsr_pkg::SEL_IDENT};
	logic [7:0] msk [13] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hf0,
		8'h00, 8'h37, 8'h00, 8'h00};
	logic [4:0] ssel [4] = '{hbsr_pkg::SEL_OC_LO, hbsr_pkg::SEL_OC_HI, hbsr_pkg::SEL_OL_LO,
		hbsr_pkg::SEL_OL_HI};
	logic [7:0] sexp [4] = '{8'h01, 8'h80, 8'h80, 8'h01};
	hbsr_if link();
	hbsr_host i_hbsr_host (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(), .link(link));
	hbsr_device #(.PART_IDENT(IDENT)) i_hbsr_device (.clk_in(clk_in), .rst_in(rst_in),
		.link(link), .global_event_in(gev), .overcurrent_event_in(oc),
		.openload_event_in(ol), .high_side_on_out(hs), .low_side_on_out(ls),
		.bridge_route_field_out(route), .channel_rate_register_out(rate),
		.duty_byte_one_out(d1), .duty_byte_two_out(d2), .duty_byte_three_out(d3),
		.overvoltage_fast_rate_out(ovp), .openload_deadtime_slew_out(olds),
		.global_diagnosis_out(gd));
	hbsr_properties i_hbsr_properties (.clk_in(clk_in), .rst_in(rst_in), .sck_in(link.sck),
		.csn_in(link.csn), .mosi_in(link.mosi), .miso_in(link.miso));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	task automatic report_and_stop();
		$display("Checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("FAIL at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	function automatic logic [7:0] fv(input int i);
		return 8'h5a ^ 8'(i * 29);
	endfunction : fv
	// Identification nibble is read-only and ignores writes
	function automatic logic [7:0] ex(input int i, input logic [7:0] v);
		return (v & msk[i]) | ((i == 12) ? {4'h0, IDENT} : 8'h00);
	endfunction : ex
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		// Only the watchdog ends a wait for ready
		do begin
			@(posedge clk_in);
		end while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic frame(input logic op, input logic [4:0] sel, input logic [7:0] d,
		output logic [15:0] r16, input logic one = 1'b1);
		logic [31:0] r;
		apb(1'b1, hbsr_pkg::HOST_CMD, {16'h0000, d, op, sel, 1'b1, one}, r);
		do begin
			apb(1'b0, hbsr_pkg::HOST_STAT, 32'h0, r);
		end while (r[0] !== 1'b0);
		apb(1'b0, hbsr_pkg::HOST_RESP, 32'h0, r);
		r16 = r[15:0];
	endtask : frame
	task automatic t_reset();
		for (int i = 0; i < 13; i++) begin
			frame(1'b0, sels[i], 8'hff, rsp);
			check(rsp[15:8], ex(i, 8'h00));
		end
		check({hs, ls}, 16'h0000);
		check({gd, d1}, 16'h0800);
	endtask : t_reset
	task automatic t_write();
		for (int i = 0; i < 13; i++)
			frame(1'b1, sels[i], fv(i), rsp);
		for (int i = 0; i < 13; i++) begin
			frame(1'b0, sels[i], ~fv(i), rsp);
			check(rsp[15:8], ex(i, fv(i)));
		end
		check({d1, d2}, {fv(5), fv(6)});
		check({d3, rate}, {fv(7), fv(4)});
		check(route, {fv(3), fv(2)});
		check({ovp, olds}, {ex(8, fv(8)), ex(10, fv(10))});
		// Frames without A0 set neither write nor return data; global status still answers
		frame(1'b1, hbsr_pkg::SEL_DUTY2, 8'h77, rsp, 1'b0);
		check(d2, fv(6));
		frame(1'b0, hbsr_pkg::SEL_DUTY1, 8'h00, rsp, 1'b0);
		check(rsp, 16'h0008);
	endtask : t_write
	task automatic t_bridge();
		logic [15:0] en;
		en = 16'h1be4;
		frame(1'b1, hbsr_pkg::SEL_EN_LO, en[7:0], rsp);
		frame(1'b1, hbsr_pkg::SEL_EN_HI, en[15:8], rsp);
		for (int b = 0; b < 8; b++) begin
			ehs[b] = en[2 * b + 1] & ~en[2 * b];
			els[b] = en[2 * b] & ~en[2 * b + 1];
		end
		check({hs, ls}, {ehs, els});
	endtask : t_bridge
	task automatic t_status();
		@(posedge clk_in);
		gev <= 6'h01;
		oc <= 16'h8001;
		ol <= 16'h0180;
		@(posedge clk_in);
		gev <= 6'h00;
		oc <= 16'h0000;
		ol <= 16'h0000;
		// Second pass shows reads leave the flags standing
		for (int i = 0; i < 8; i++) begin
			frame(1'b0, ssel[i % 4], 8'h00, rsp);
			check(rsp, {sexp[i % 4], 8'h0a});
		end
		for (int i = 0; i < 4; i++) begin
			frame(1'b1, ssel[i], 8'h00, rsp);
			frame(1'b0, ssel[i], 8'h00, rsp);
			check(rsp[15:8], 8'h00);
		end
		frame(1'b1, hbsr_pkg::SEL_GLOBAL, 8'h00, rsp);
		check(gd, 8'h00);
	endtask : t_status
	task automatic t_rereset();
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		check({hs, ls}, 16'h0000);
		check({gd, d3}, 16'h0800);
		frame(1'b0, hbsr_pkg::SEL_DUTY1, 8'h00, rsp);
		check(rsp, 16'h0008);
	endtask : t_rereset
	initial begin
		repeat (60000) @(posedge clk_in);
		errors++;
		report_and_stop();
	end
	initial begin
		rst_in = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		gev = 6'h00;
		oc = 16'h0000;
		ol = 16'h0000;
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_write();
		t_bridge();
		t_status();
		t_rereset();
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
